// ### rtl/spinb_pkg.sv
/*
 * constants, register map and state type of the serial master with
 * nine-bit command mode.
 * assumes a 32-bit apb register bus and one core clock.
 */
package spinb_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FIFO = 8'h04;
    localparam logic [7:0] OFS_DIV = 8'h08;
    localparam logic [7:0] OFS_LEN = 8'h0C;
    localparam logic [7:0] OFS_HOLD = 8'h10;
    localparam logic [7:0] OFS_DC = 8'h14;
    localparam logic [7:0] OFS_MISC = 8'h18;
    localparam int B_LONG = 25;
    localparam int B_NDMA = 24;
    localparam int B_POL0 = 21;
    localparam int B_RXF = 20;
    localparam int B_RXR = 19;
    localparam int B_TXR = 18;
    localparam int B_RXD = 17;
    localparam int B_DONE = 16;
    localparam int B_NINE = 13;
    localparam int B_RDIR = 12;
    localparam int B_ADES = 11;
    localparam int B_DMAEN = 8;
    localparam int B_TA = 7;
    localparam int B_SPOL = 6;
    localparam int B_CLRRX = 5;
    localparam int B_CLRTX = 4;
    localparam int B_CLOCK_POLARITY = 3;
    localparam int B_CLOCK_PHASE = 2;
    localparam logic [31:0] CTRL_WMASK = 32'h03E0_FFCF;
    localparam logic [31:0] CTRL_RST = 32'h0000_1000;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam logic [2:0] CS_RST = 3'h7;
    localparam logic OE_RST = 1'h1;
    localparam int DEPTH = 16;
    localparam int AW = 4;
    localparam logic [4:0] RXR_LEVEL = 5'h0C;
    localparam logic [7:0] CMD_R24 = 8'h04;
    localparam logic [7:0] CMD_R32 = 8'h09;
    localparam logic [7:0] CMD_B1_LO = 8'h0A;
    localparam logic [7:0] CMD_B1_HI = 8'h0F;
    localparam logic [7:0] CMD_B2_LO = 8'hDA;
    localparam logic [7:0] CMD_B2_HI = 8'hDC;
    localparam logic [5:0] NB_BYTE = 6'h08;
    localparam logic [5:0] NB_R24 = 6'h18;
    localparam logic [5:0] NB_R32 = 6'h20;
    localparam logic [5:0] NB_NINE = 6'h09;
    localparam logic [5:0] NB_NINE_LONG = 6'h24;
    localparam logic [15:0] DIV_ZERO_HALF = 16'h8000;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} spinb_state_t;
endpackage : spinb_pkg

// ### rtl/spinb_top.sv
/*
 * serial master with plain spi and nine-bit command/parameter mode,
 * apb slave registers, transmit and receive fifos, serial engine.
 * assumes an apb master on clk_sys_i; miso_i comes from a pin and the
 * bench resolves the shared data wire from mosi_oe_o.
 */
`timescale 1ns/1ps
// Operation
// - nine-bit frames carry type flag plus byte
// - detected read command runs whole read itself
// - codes 0A-0F, DA-DC read one byte
// - code 04 reads a 24-bit word
// - code 09 reads 32 bits msb first
// - with nine-bit dma, long word bit selects byte or word writes
// - nine-bit dma enable bit, resets zero
// - per-select polarity bits, active low default
// - full rx fifo stops serial traffic
// - tx room flag, reads one after reset
// - rx data flag while fifo not empty
// - done flag after transfer, cleared by tx fifo writes
// - mode bit picks plain or nine-bit master
// - in plain mode, read direction with misc bit 0 set turns shared wire around
// - auto deselect after programmed dma length
// - registers decoded at fixed word offsets
// - inactive transfer parks selects, loads config
// - clock polarity and phase shape sclk
// - data shifted msb first both ways
module spinb_top (
    input logic clk_sys_i,
    input logic rst_n_i,
    input logic psel_i,
    input logic penable_i,
    input logic pwrite_i,
    input logic [7:0] paddr_i,
    input logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic sclk_o,
    output logic mosi_o,
    output logic mosi_oe_o,
    input logic miso_i,
    output logic [2:0] cs_o
);
    localparam int DEPTH = spinb_pkg::DEPTH;
    localparam int AW = spinb_pkg::AW;

    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [1:0] miso_sync_ff;
    logic miso_s;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    // pin input, two stages before use
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            miso_sync_ff <= 2'h0;
        end else begin
            miso_sync_ff <= {miso_sync_ff[0], miso_i};
        end
    end
    assign miso_s = miso_sync_ff[1];

    logic [31:0] ctrl_ff, nxt_ctrl, len_ff, nxt_len, div_ff, nxt_div;
    logic [31:0] hold_ff, nxt_hold, dc_ff, nxt_dc;
    logic misc_ff, nxt_misc, desel_ff, nxt_desel;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [2:0] cs_ff, nxt_cs, pol_vec;
    logic [31:0] tx_mem_ff [DEPTH];
    logic [31:0] nxt_tx_mem [DEPTH];
    logic [31:0] rx_mem_ff [DEPTH];
    logic [31:0] nxt_rx_mem [DEPTH];
    logic [DEPTH-1:0] tx_long_ff, nxt_tx_long;
    logic [AW:0] tx_wp_ff, nxt_tx_wp, tx_rp_ff, nxt_tx_rp;
    logic [AW:0] rx_wp_ff, nxt_rx_wp, rx_rp_ff, nxt_rx_rp;
    logic pready_ff, nxt_pready, slverr_ff, nxt_slverr;
    logic [31:0] prdata_ff, nxt_prdata, status, wdat;
    spinb_pkg::spinb_state_t st_ff, nxt_st;
    logic [15:0] div_cnt_ff, nxt_div_cnt, hold_cnt_ff, nxt_hold_cnt, half;
    logic phase_ff, nxt_phase, push_ff, nxt_push;
    logic [5:0] bit_ff, nxt_bit, tot_ff, nxt_tot, txb_ff, nxt_txb, rd_bits;
    logic [35:0] osr_ff, nxt_osr;
    logic [31:0] isr_ff, nxt_isr, head;
    logic sclk_ff, nxt_sclk, mosi_ff, nxt_mosi, oe_ff, nxt_oe;
    logic [AW:0] tx_cnt, rx_cnt;
    logic tx_empty, tx_full, rx_empty, rx_full, ta, nine, dma_on, head_long;
    logic acc, xfer, wr_ctrl, wr_fifo, rd_fifo, clr_tx, clr_rx;
    logic start, tick, rx_push, push_tx;

    assign tx_cnt = tx_wp_ff - tx_rp_ff;
    assign rx_cnt = rx_wp_ff - rx_rp_ff;
    assign tx_empty = (tx_cnt == '0);
    assign tx_full = tx_cnt[AW];
    assign rx_empty = (rx_cnt == '0);
    assign rx_full = rx_cnt[AW];
    assign ta = ctrl_ff[spinb_pkg::B_TA];
    assign nine = ctrl_ff[spinb_pkg::B_NINE];
    assign dma_on = ctrl_ff[spinb_pkg::B_DMAEN] | (nine & ctrl_ff[spinb_pkg::B_NDMA]);
    assign acc = psel_i & penable_i;
    assign xfer = acc & pready_ff;
    assign wr_ctrl = xfer & pwrite_i & (paddr_i == spinb_pkg::OFS_CTRL);
    assign wr_fifo = xfer & pwrite_i & (paddr_i == spinb_pkg::OFS_FIFO);
    assign rd_fifo = xfer & ~pwrite_i & (paddr_i == spinb_pkg::OFS_FIFO);
    assign wdat = pwdata_i & spinb_pkg::CTRL_WMASK;
    assign head = tx_mem_ff[tx_rp_ff[AW-1:0]];
    assign head_long = tx_long_ff[tx_rp_ff[AW-1:0]];
    // a frame starts only with a free rx slot, so it never overruns
    assign start = (st_ff == spinb_pkg::ST_IDLE) & ta & ~desel_ff & ~tx_empty & ~rx_full;
    assign tick = (div_cnt_ff == 16'h0000);
    assign half = (div_ff[15:0] == 16'h0000) ? spinb_pkg::DIV_ZERO_HALF :
                  (div_ff[15:1] == 15'h0000) ? 16'h0001 : {1'h0, div_ff[15:1]};

    // read command decode on the head entry; type flag low means command
    always_comb begin
        rd_bits = 6'h00;
        if (!head[8]) begin
            if ((head[7:0] >= spinb_pkg::CMD_B1_LO && head[7:0] <= spinb_pkg::CMD_B1_HI) ||
                (head[7:0] >= spinb_pkg::CMD_B2_LO && head[7:0] <= spinb_pkg::CMD_B2_HI)) begin
                rd_bits = spinb_pkg::NB_BYTE;
            end else if (head[7:0] == spinb_pkg::CMD_R24) begin
                rd_bits = spinb_pkg::NB_R24;
            end else if (head[7:0] == spinb_pkg::CMD_R32) begin
                rd_bits = spinb_pkg::NB_R32;
            end
        end
    end

    always_comb begin
        status = ctrl_ff;
        status[spinb_pkg::B_RXF] = rx_full;
        status[spinb_pkg::B_RXR] = ta & (rx_cnt >= spinb_pkg::RXR_LEVEL);
        status[spinb_pkg::B_TXR] = ~tx_full;
        status[spinb_pkg::B_RXD] = ~rx_empty;
        status[spinb_pkg::B_DONE] = ta & tx_empty & (st_ff == spinb_pkg::ST_IDLE);
    end

    // apb slave, one wait state; reads return state of the cycle before pready
    always_comb begin
        nxt_pready = acc & ~pready_ff;
        nxt_prdata = prdata_ff;
        nxt_slverr = 1'h0;
        if (acc && !pready_ff) begin
            nxt_prdata = spinb_pkg::REG_RST;
            case (paddr_i)
                spinb_pkg::OFS_CTRL: nxt_prdata = status;
                spinb_pkg::OFS_FIFO: nxt_prdata = rx_empty ? spinb_pkg::REG_RST : rx_mem_ff[rx_rp_ff[AW-1:0]];
                spinb_pkg::OFS_DIV: nxt_prdata = div_ff;
                spinb_pkg::OFS_LEN: nxt_prdata = len_ff;
                spinb_pkg::OFS_HOLD: nxt_prdata = hold_ff;
                spinb_pkg::OFS_DC: nxt_prdata = dc_ff;
                spinb_pkg::OFS_MISC: nxt_prdata = {31'h0, misc_ff};
                default: nxt_slverr = 1'h1;
            endcase
            if (pwrite_i) begin
                nxt_prdata = spinb_pkg::REG_RST;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff <= 1'h0;
            slverr_ff <= 1'h0;
            prdata_ff <= spinb_pkg::REG_RST;
        end else begin
            pready_ff <= nxt_pready;
            slverr_ff <= nxt_slverr;
            prdata_ff <= nxt_prdata;
        end
    end

    // control registers; bits 15:14 are storage only
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_len = len_ff;
        nxt_div = div_ff;
        nxt_hold = hold_ff;
        nxt_dc = dc_ff;
        nxt_misc = misc_ff;
        nxt_desel = desel_ff;
        nxt_cnt = cnt_ff;
        clr_tx = 1'h0;
        clr_rx = 1'h0;
        if (wr_ctrl) begin
            nxt_ctrl = wdat;
            clr_tx = pwdata_i[spinb_pkg::B_CLRTX];
            clr_rx = pwdata_i[spinb_pkg::B_CLRRX];
        end
        if (wr_fifo && !ta) begin
            nxt_ctrl[7:0] = wdat[7:0];
            nxt_len[15:0] = pwdata_i[15:0];
            clr_tx = pwdata_i[spinb_pkg::B_CLRTX];
            clr_rx = pwdata_i[spinb_pkg::B_CLRRX];
        end
        if (xfer && pwrite_i) begin
            case (paddr_i)
                spinb_pkg::OFS_DIV: nxt_div = pwdata_i;
                spinb_pkg::OFS_LEN: nxt_len = pwdata_i;
                spinb_pkg::OFS_HOLD: nxt_hold = pwdata_i;
                spinb_pkg::OFS_DC: nxt_dc = pwdata_i;
                spinb_pkg::OFS_MISC: nxt_misc = pwdata_i[0];
                default: nxt_misc = misc_ff;
            endcase
        end
        if (!ta) begin
            nxt_cnt = 16'h0000;
            nxt_desel = 1'h0;
        end else begin
            if (start && dma_on) begin
                nxt_cnt = cnt_ff + (head_long ? 16'h0004 : 16'h0001);
            end
            // waits for the engine so the select spans the last frame
            if (ctrl_ff[spinb_pkg::B_ADES] && dma_on && (st_ff == spinb_pkg::ST_IDLE) && !start &&
                (len_ff[15:0] != 16'h0000) && (cnt_ff >= len_ff[15:0])) begin
                nxt_desel = 1'h1;
            end
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_cs
        assign pol_vec[g] = ctrl_ff[spinb_pkg::B_POL0 + g] | ctrl_ff[spinb_pkg::B_SPOL];
        assign nxt_cs[g] = (ta & ~desel_ff & (ctrl_ff[1:0] == 2'(g))) ~^ pol_vec[g];
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= spinb_pkg::CTRL_RST;
            len_ff <= spinb_pkg::REG_RST;
            div_ff <= spinb_pkg::REG_RST;
            hold_ff <= spinb_pkg::REG_RST;
            dc_ff <= spinb_pkg::REG_RST;
            misc_ff <= 1'h0;
            desel_ff <= 1'h0;
            cnt_ff <= 16'h0000;
            cs_ff <= spinb_pkg::CS_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
            len_ff <= nxt_len;
            div_ff <= nxt_div;
            hold_ff <= nxt_hold;
            dc_ff <= nxt_dc;
            misc_ff <= nxt_misc;
            desel_ff <= nxt_desel;
            cnt_ff <= nxt_cnt;
            cs_ff <= nxt_cs;
        end
    end

    // fifos; a write to a full tx fifo is dropped
    assign push_tx = wr_fifo & ta & ~tx_full;
    always_comb begin
        nxt_tx_mem = tx_mem_ff;
        nxt_tx_long = tx_long_ff;
        nxt_rx_mem = rx_mem_ff;
        nxt_tx_wp = tx_wp_ff + {{AW{1'h0}}, push_tx};
        nxt_tx_rp = clr_tx ? tx_wp_ff : tx_rp_ff + {{AW{1'h0}}, start};
        nxt_rx_wp = rx_wp_ff + {{AW{1'h0}}, rx_push};
        nxt_rx_rp = clr_rx ? rx_wp_ff : rx_rp_ff + {{AW{1'h0}}, rd_fifo & ~rx_empty};
        if (push_tx) begin
            nxt_tx_mem[tx_wp_ff[AW-1:0]] = pwdata_i;
            nxt_tx_long[tx_wp_ff[AW-1:0]] = (nine & ctrl_ff[spinb_pkg::B_NDMA] &
                ctrl_ff[spinb_pkg::B_LONG]) | (~nine & ctrl_ff[spinb_pkg::B_DMAEN]);
        end
        if (rx_push) begin
            nxt_rx_mem[rx_wp_ff[AW-1:0]] = isr_ff;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_mem_ff <= '{default: 32'h0000_0000};
            rx_mem_ff <= '{default: 32'h0000_0000};
            tx_long_ff <= '0;
            tx_wp_ff <= '0;
            tx_rp_ff <= '0;
            rx_wp_ff <= '0;
            rx_rp_ff <= '0;
        end else begin
            tx_mem_ff <= nxt_tx_mem;
            rx_mem_ff <= nxt_rx_mem;
            tx_long_ff <= nxt_tx_long;
            tx_wp_ff <= nxt_tx_wp;
            tx_rp_ff <= nxt_tx_rp;
            rx_wp_ff <= nxt_rx_wp;
            rx_rp_ff <= nxt_rx_rp;
        end
    end

    // serial engine; sampling uses the synchronised pin, two cycles late
    always_comb begin
        nxt_st = st_ff;
        nxt_div_cnt = div_cnt_ff;
        nxt_hold_cnt = hold_cnt_ff;
        nxt_phase = phase_ff;
        nxt_bit = bit_ff;
        nxt_tot = tot_ff;
        nxt_txb = txb_ff;
        nxt_osr = osr_ff;
        nxt_isr = isr_ff;
        nxt_push = push_ff;
        rx_push = 1'h0;
        case (st_ff)
            spinb_pkg::ST_IDLE: begin
                if (start) begin
                    nxt_st = spinb_pkg::ST_RUN;
                    nxt_div_cnt = half - 16'h0001;
                    nxt_phase = 1'h0;
                    nxt_bit = 6'h00;
                    nxt_isr = 32'h0000_0000;
                    if (nine && head_long) begin
                        nxt_osr = {1'h1, head[31:24], 1'h1, head[23:16], 1'h1, head[15:8], 1'h1, head[7:0]};
                        nxt_txb = spinb_pkg::NB_NINE_LONG;
                        nxt_tot = spinb_pkg::NB_NINE_LONG;
                        nxt_push = 1'h0;
                    end else if (nine) begin
                        nxt_osr = {head[8:0], 27'h0};
                        nxt_txb = spinb_pkg::NB_NINE;
                        nxt_tot = spinb_pkg::NB_NINE + rd_bits;
                        nxt_push = (rd_bits != 6'h00);
                    end else if (head_long) begin
                        nxt_osr = {head, 4'h0};
                        nxt_txb = spinb_pkg::NB_R32;
                        nxt_tot = spinb_pkg::NB_R32;
                        nxt_push = 1'h1;
                    end else begin
                        nxt_osr = {head[7:0], 28'h0};
                        nxt_txb = spinb_pkg::NB_BYTE;
                        nxt_tot = spinb_pkg::NB_BYTE;
                        nxt_push = 1'h1;
                    end
                end
            end
            spinb_pkg::ST_RUN: begin
                if (tick) begin
                    nxt_div_cnt = half - 16'h0001;
                    if (!phase_ff) begin
                        nxt_phase = 1'h1;
                        if (!nine || bit_ff >= txb_ff) begin
                            nxt_isr = {isr_ff[30:0], miso_s};
                        end
                    end else begin
                        nxt_phase = 1'h0;
                        nxt_bit = bit_ff + 6'h01;
                        nxt_osr = {osr_ff[34:0], 1'h0};
                        if (nxt_bit == tot_ff) begin
                            rx_push = push_ff;
                            nxt_hold_cnt = hold_ff[15:0];
                            nxt_st = (nine && hold_ff[15:0] != 16'h0000) ? spinb_pkg::ST_HOLD : spinb_pkg::ST_IDLE;
                        end
                    end
                end else begin
                    nxt_div_cnt = div_cnt_ff - 16'h0001;
                end
            end
            spinb_pkg::ST_HOLD: begin
                nxt_hold_cnt = hold_cnt_ff - 16'h0001;
                if (hold_cnt_ff <= 16'h0001) begin
                    nxt_st = spinb_pkg::ST_IDLE;
                end
            end
            default: nxt_st = spinb_pkg::ST_IDLE;
        endcase
        nxt_sclk = ctrl_ff[spinb_pkg::B_CLOCK_POLARITY];
        if (nxt_st == spinb_pkg::ST_RUN) begin
            nxt_sclk = ctrl_ff[spinb_pkg::B_CLOCK_POLARITY] ^ ctrl_ff[spinb_pkg::B_CLOCK_PHASE] ^ nxt_phase;
        end
        nxt_mosi = nxt_osr[35];
        nxt_oe = ~((nine & (nxt_st == spinb_pkg::ST_RUN) & (nxt_bit >= nxt_txb)) |
                   (~nine & misc_ff & ctrl_ff[spinb_pkg::B_RDIR]));
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= spinb_pkg::ST_IDLE;
            div_cnt_ff <= 16'h0000;
            hold_cnt_ff <= 16'h0000;
            phase_ff <= 1'h0;
            bit_ff <= 6'h00;
            tot_ff <= 6'h00;
            txb_ff <= 6'h00;
            osr_ff <= 36'h0_0000_0000;
            isr_ff <= 32'h0000_0000;
            push_ff <= 1'h0;
            sclk_ff <= 1'h0;
            mosi_ff <= 1'h0;
            oe_ff <= spinb_pkg::OE_RST;
        end else begin
            st_ff <= nxt_st;
            div_cnt_ff <= nxt_div_cnt;
            hold_cnt_ff <= nxt_hold_cnt;
            phase_ff <= nxt_phase;
            bit_ff <= nxt_bit;
            tot_ff <= nxt_tot;
            txb_ff <= nxt_txb;
            osr_ff <= nxt_osr;
            isr_ff <= nxt_isr;
            push_ff <= nxt_push;
            sclk_ff <= nxt_sclk;
            mosi_ff <= nxt_mosi;
            oe_ff <= nxt_oe;
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = slverr_ff;
    assign sclk_o = sclk_ff;
    assign mosi_o = mosi_ff;
    assign mosi_oe_o = oe_ff;
    assign cs_o = cs_ff;

    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence

    chk_apb_wait_state: assert property (s_setup ##1 s_access |-> !pready_ff ##1 pready_ff)
        else $error("apb answer not after one wait state");
    chk_flag_first: assert property (start && nine && !head_long |=> mosi_ff == $past(head[8]) && oe_ff)
        else $error("type flag not first on data line");
    chk_byte_read: assert property (start && nine && !head_long && rd_bits == 6'h08 |=> tot_ff == 6'h11)
        else $error("byte read length wrong");
    chk_read_24: assert property (start && nine && !head_long && head[8:0] == 9'h004 |=> tot_ff == 6'h21)
        else $error("24-bit read length wrong");
    chk_read_32: assert property (start && nine && !head_long && head[8:0] == 9'h009 |=> tot_ff == 6'h29)
        else $error("32-bit read length wrong");
    chk_rx_full_stall: assert property (rx_full && st_ff == spinb_pkg::ST_IDLE |=> st_ff == spinb_pkg::ST_IDLE)
        else $error("frame started with full rx fifo");
    chk_cs_parked: assert property (!ta |=> cs_ff == ~$past(pol_vec))
        else $error("select active while transfer inactive");
    chk_sclk_idle: assert property (st_ff == spinb_pkg::ST_IDLE |-> sclk_ff == $past(ctrl_ff[spinb_pkg::B_CLOCK_POLARITY]))
        else $error("sclk not at idle level");
    chk_msb_order: assert property (st_ff == spinb_pkg::ST_RUN && tick && phase_ff |=> mosi_ff == $past(osr_ff[34]))
        else $error("data not shifted msb first");
endmodule : spinb_top

// ### testbench/spinb_periph.sv
/* peer model of a nine-bit command peripheral on the serial pins.
   assumes clock polarity 0, phase 0 and one select line. */
`timescale 1ns/1ps
module spinb_periph (
    input wire logic sclk_i,
    input wire logic sel_i,
    input wire logic sd_i,
    input wire logic [31:0] resp_i,
    output logic sd_o,
    output logic sd_oe_o,
    output logic [8:0] got_o,
    output logic [31:0] nfr_o
);
    int nb = 0;
    int nr = 0;
    logic [31:0] rv;
    function automatic int rd_len(input logic [8:0] w);
        if (w[8]) return 0;
        if (w[7:0] inside {[8'h0A:8'h0F], [8'hDA:8'hDC]}) return 8;
        if (w[7:0] == 8'h04) return 24;
        if (w[7:0] == 8'h09) return 32;
        return 0;
    endfunction : rd_len
    initial begin
        sd_o = 1'b0;
        sd_oe_o = 1'b0;
        got_o = 9'h0;
        nfr_o = 32'h0;
    end
    always @(posedge sclk_i) begin
        if (sel_i) begin
            if (nb < 9) got_o <= {got_o[7:0], sd_i};
            nb <= nb + 1;
        end
    end
    // answer bits change at bit end so they are stable at mid-bit
    always @(negedge sclk_i) begin
        if (nb == 9) begin
            nr = rd_len(got_o);
            rv = resp_i + nfr_o;
        end
        if (nb >= 9 && nb - 9 < nr) begin
            sd_oe_o <= 1'b1;
            sd_o <= rv[nr - 1 - (nb - 9)];
        end else if (nb >= 9) begin
            sd_oe_o <= 1'b0;
            nfr_o <= nfr_o + 1;
            nb = 0;
        end
    end
endmodule : spinb_periph

// ### testbench/tb.sv
/* self-checking bench: apb host, peer model, queue of expected reads.
   assumes spinb_pkg and spinb_periph are compiled first. */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("BAD t=%0t %h %h", $time, a, b); end end
module tb;
    logic clk_sys_i, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready_o, pslverr_o, sclk_o, mosi_o, mosi_oe_o, wire_sd, wlast = 1'b0, p_d, p_oe;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata_o, resp = 32'h0, r, seed = 32'hFFB7, peer_cnt;
    logic [2:0] cs_o;
    logic [8:0] peer_got;
    int checks = 0, error_cnt = 0, nf = 0;
    logic [31:0] exq[$];
    logic [7:0] codes[11] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'hDA, 8'hDB, 8'hDC, 8'h04, 8'h09};
    spinb_top i_spinb_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .sclk_o(sclk_o), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(wire_sd),
        .cs_o(cs_o));
    spinb_periph u_peer (.sclk_i(sclk_o), .sel_i(cs_o == 3'h6), .sd_i(wire_sd), .resp_i(resp), .sd_o(p_d),
        .sd_oe_o(p_oe), .got_o(peer_got), .nfr_o(peer_cnt));
    // undriven shared wire toggles so a stale bit never looks valid
    assign wire_sd = mosi_oe_o ? mosi_o : (p_oe ? p_d : ~wlast);
    always @(posedge clk_sys_i) wlast <= wire_sd;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic e;
        apb(1'b1, a, d, e);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic e;
        apb(1'b0, a, 32'h0, e);
    endtask : rd
    task automatic wbit(input int b);
        int n = 0;
        do begin
            rd(spinb_pkg::OFS_CTRL);
            n++;
        end while (r[b] !== 1'b1 && n < 3000);
        `CHK(r[b], 1'b1)
    endtask : wbit
    task automatic cmd(input logic [7:0] c);
        int len;
        len = u_peer.rd_len({1'b0, c});
        if (len > 0) exq.push_back((resp + nf) & (len == 32 ? 32'hFFFF_FFFF : (32'h1 << len) - 1));
        nf++;
        wr(spinb_pkg::OFS_FIFO, {24'h0, c});
    endtask : cmd
    task automatic pop();
        logic [31:0] x;
        x = exq.pop_front();
        rd(spinb_pkg::OFS_FIFO);
        `CHK(r, x)
    endtask : pop
    task automatic end_sim();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        error_cnt++;
        end_sim();
    end
    initial begin
        logic [31:0] d;
        logic e;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        rd(spinb_pkg::OFS_CTRL);
        `CHK(r, 32'h0004_1000)
        wr(spinb_pkg::OFS_CTRL, 32'h03E0_C008);
        rd(spinb_pkg::OFS_CTRL);
        `CHK(r, 32'h03E4_C008)
        `CHK({sclk_o, cs_o}, 4'h8)
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF, e);
        `CHK(e, 1'b1)
        apb(1'b0, 8'h1C, 32'h0, e);
        `CHK({e, r}, 33'h1_0000_0000)
        wr(spinb_pkg::OFS_DIV, 32'h8);
        wr(spinb_pkg::OFS_CTRL, 32'h2080);
        // selects settle one edge after the control write lands
        @(posedge clk_sys_i);
        `CHK(cs_o, 3'h6)
        resp = rnd();
        for (int i = 0; i < 4; i++) begin
            d = rnd();
            d = {23'h0, 1'b1, d[7:0]};
            nf++;
            wr(spinb_pkg::OFS_FIFO, d);
            wbit(16);
            `CHK(peer_got, d[8:0])
        end
        cmd(8'h2C);
        wbit(16);
        `CHK({peer_got, r[17]}, 10'h058)
        foreach (codes[i]) begin
            cmd(codes[i]);
            wbit(16);
            pop();
        end
        // rx fills after sixteen reads, then tx fills behind the stall
        for (int i = 0; i < 16; i++) cmd(8'h0A + 8'(i % 6));
        wbit(16);
        `CHK(r[20:16], 5'h1F)
        for (int i = 0; i < 16; i++) cmd(8'hDA + 8'(i % 3));
        repeat (300) @(posedge clk_sys_i);
        rd(spinb_pkg::OFS_CTRL);
        `CHK({peer_cnt, r[20:16]}, {32'(nf - 16), 5'h1A})
        for (int i = 0; i < 32; i++) begin
            wbit(17);
            pop();
        end
        rd(spinb_pkg::OFS_CTRL);
        `CHK(r[20:16], 5'h05)
        wr(spinb_pkg::OFS_CTRL, 32'h0300_2080);
        d = rnd();
        nf += 4;
        wr(spinb_pkg::OFS_FIFO, d);
        wbit(16);
        `CHK({peer_cnt, peer_got}, {32'(nf), 1'b1, d[7:0]})
        wr(spinb_pkg::OFS_CTRL, 32'h0);
        rd(spinb_pkg::OFS_CTRL);
        `CHK({cs_o, r[20:16]}, 8'hE4)
        // plain spi: mosi loops back onto the wire while the peer stays off it
        wr(spinb_pkg::OFS_CTRL, 32'h0080);
        d = rnd();
        exq.push_back({24'h0, d[7:0]});
        wr(spinb_pkg::OFS_FIFO, d);
        wbit(16);
        pop();
        wr(spinb_pkg::OFS_LEN, 32'h4);
        wr(spinb_pkg::OFS_CTRL, 32'h098C);
        d = rnd();
        exq.push_back(d);
        wr(spinb_pkg::OFS_FIFO, d);
        wbit(16);
        repeat (2) @(posedge clk_sys_i);
        `CHK({cs_o, sclk_o}, 4'hF)
        pop();
        wr(spinb_pkg::OFS_MISC, 32'h1);
        wr(spinb_pkg::OFS_CTRL, 32'h1080);
        @(posedge clk_sys_i);
        `CHK(mosi_oe_o, 1'b0)
        end_sim();
    end
endmodule : tb
